/* File: autoneg_mgmt_registers.sv */
// Negotiation management registers behind a serial management slave.
//------------------------------------------------------------------
// What this block does
// [RULE1] Words 2 and 3 return the organisation identifier; model, revision read zero.
// [RULE2] Remote fault field is writable and clears to 00 after negotiation.
// [RULE3] Pause field is writable, encodes four modes, resets to 11.
// [RULE4] Local next-page bit reads 0 and ignores writes.
// [RULE5] Full-duplex bit is writable, resets to 1, only advertised.
// [RULE6] Half-duplex bit always reads 0.
// [RULE7] Reserved advertisement bits read zero and discard writes.
// [RULE8] Advertisement may also be loaded through the configuration port.
// [RULE9] Word 5 shows the partner base page, read-only, reset to zero.
// [RULE10] Page-received flag sets on a new page, clears when read.
// [RULE11] Next-page-able bit in the expansion word always reads 1.
// [RULE12] Next-page transmit word holds writable bits; code defaults to null.
// [RULE13] Message-page bit selects message code or unformatted data.
// [RULE14] Transmit toggle bit alternates between successive next pages.
// [RULE15] Without next-page support the transmit word reads all zeros.
// [RULE16] Word 8 shows the partner next page, read-only, reset to zero.
// [RULE17] Undefined addresses read zero and ignore writes.
// [RULE18] Core reset, lost clock lock or soft reset restore all defaults.
// [RULE19] A stored partner page sets page-received in the same cycle.
//------------------------------------------------------------------
`timescale 1ns/10ps

module autoneg_mgmt_registers #(
  parameter bit NEXT_PAGE_EN = 1'b0,
  // Identifier values are arbitrary.
  parameter logic [15:0] ORG_ID_HIGH = 16'h5a5a,
  parameter logic [5:0] ORG_ID_LOW = 6'h2c
) (
  // Clock and resets
  input wire logic clk,
  input wire logic reset,
  input wire logic soft_reset,
  input wire logic clock_manager_locked,
  // Management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  input wire logic [4:0] phy_addr,
  // Negotiation engine
  input wire autoneg_pkg::page_in_t page_in,
  input wire autoneg_pkg::adv_cfg_t adv_cfg,
  input wire logic an_complete,
  input wire logic np_sent,
  output logic [15:0] local_adv,
  output logic [15:0] np_tx_word
);
  import autoneg_pkg::*;

  //------------------------------------------------------------------
  // Synchronisers and reset
  //------------------------------------------------------------------
  logic mdc_s1_reg, mdc_s2_reg, mdc_prev_reg;
  logic mdio_s1_reg, mdio_s2_reg;
  logic lock_s1_reg, lock_s2_reg;
  logic mdc_rise;
  logic rst;

  always_ff @(posedge clk) begin
    if (reset) begin
      mdc_s1_reg <= 1'b0;
      mdc_s2_reg <= 1'b0;
      mdc_prev_reg <= 1'b0;
      mdio_s1_reg <= 1'b1;
      mdio_s2_reg <= 1'b1;
      lock_s1_reg <= 1'b0;
      lock_s2_reg <= 1'b0;
    end else begin
      mdc_s1_reg <= mdc;
      mdc_s2_reg <= mdc_s1_reg;
      mdc_prev_reg <= mdc_s2_reg;
      mdio_s1_reg <= mdio_in;
      mdio_s2_reg <= mdio_s1_reg;
      lock_s1_reg <= clock_manager_locked;
      lock_s2_reg <= lock_s1_reg;
    end
  end

  assign mdc_rise = mdc_s2_reg & ~mdc_prev_reg;
  assign rst = reset | soft_reset | ~lock_s2_reg; // RULE18

  //------------------------------------------------------------------
  // Management frame engine
  //------------------------------------------------------------------
  mgmt_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [11:0] hdr_reg;
  logic [11:0] hdr_next;
  logic [4:0] addr_reg;
  logic rd_hit_reg, wr_hit_reg;
  logic [15:0] sh_reg;
  logic [15:0] rd_word;
  logic wr_en_reg;
  logic [4:0] wr_addr_reg;
  logic [15:0] wr_data_reg;
  logic rd_exp_reg;

  assign hdr_next = {hdr_reg[10:0], mdio_s2_reg};

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      cnt_reg <= 4'h0;
      hdr_reg <= 12'h000;
      addr_reg <= 5'h00;
      rd_hit_reg <= 1'b0;
      wr_hit_reg <= 1'b0;
      sh_reg <= 16'h0000;
      mdio_out <= 1'b1;
      mdio_oe_n <= 1'b1;
      wr_en_reg <= 1'b0;
      wr_addr_reg <= 5'h00;
      wr_data_reg <= 16'h0000;
      rd_exp_reg <= 1'b0;
    end else begin
      wr_en_reg <= 1'b0;
      rd_exp_reg <= 1'b0;
      if (mdc_rise) begin
        unique case (state_reg)
          S_IDLE: begin
            if (!mdio_s2_reg) begin
              state_reg <= S_START;
            end
          end
          S_START: begin
            if (mdio_s2_reg) begin
              state_reg <= S_HDR;
              cnt_reg <= 4'h0;
            end
          end
          S_HDR: begin
            hdr_reg <= hdr_next;
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == HDR_LAST) begin
              state_reg <= S_TA;
              cnt_reg <= 4'h0;
              addr_reg <= hdr_next[4:0];
              rd_hit_reg <= hdr_next[11:10] == OP_READ &&
                            hdr_next[9:5] == phy_addr;
              wr_hit_reg <= hdr_next[11:10] == OP_WRITE &&
                            hdr_next[9:5] == phy_addr;
            end
          end
          S_TA: begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg != TA_LAST) begin
              if (rd_hit_reg) begin
                mdio_oe_n <= 1'b0;
                mdio_out <= 1'b0;
                sh_reg <= rd_word;
                rd_exp_reg <= addr_reg == ADDR_EXPANSION; // RULE10
              end
            end else begin
              state_reg <= S_DATA;
              cnt_reg <= 4'h0;
              if (rd_hit_reg) begin
                mdio_out <= sh_reg[15];
                sh_reg <= {sh_reg[14:0], 1'b0};
              end
            end
          end
          S_DATA: begin
            cnt_reg <= cnt_reg + 4'h1;
            if (rd_hit_reg) begin
              mdio_out <= sh_reg[15];
              sh_reg <= {sh_reg[14:0], 1'b0};
            end else begin
              sh_reg <= {sh_reg[14:0], mdio_s2_reg};
            end
            if (cnt_reg == DATA_LAST) begin
              state_reg <= S_IDLE;
              mdio_oe_n <= 1'b1;
              mdio_out <= 1'b1;
              wr_en_reg <= wr_hit_reg;
              wr_addr_reg <= addr_reg;
              wr_data_reg <= {sh_reg[14:0], mdio_s2_reg};
            end
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

  //------------------------------------------------------------------
  // Register storage
  //------------------------------------------------------------------
  logic [15:0] partner_base_reg;
  logic [15:0] np_rx_reg;
  logic page_rx_reg;
  logic wr_adv, wr_nptx;

  assign wr_adv = wr_en_reg && wr_addr_reg == ADDR_LOCAL_ADV;
  assign wr_nptx = wr_en_reg && wr_addr_reg == ADDR_NP_TX;

  always_ff @(posedge clk) begin
    if (rst) begin
      local_adv <= ADV_RESET; // RULE3 RULE5
    end else begin
      if (adv_cfg.valid) begin
        local_adv <= adv_cfg.word & ADV_WR_MASK; // RULE8
      end
      if (wr_adv) begin
        local_adv <= wr_data_reg & ADV_WR_MASK; // RULE4 RULE6 RULE7
      end
      if (an_complete) begin
        local_adv[ADV_RF_HI:ADV_RF_LO] <= RF_NO_ERROR; // RULE2
        if (wr_adv) begin
          local_adv[ADV_PAUSE_HI:ADV_PAUSE_LO] <=
            wr_data_reg[ADV_PAUSE_HI:ADV_PAUSE_LO];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      np_tx_word <= NPTX_RESET; // RULE12
    end else begin
      if (wr_nptx) begin
        np_tx_word <= (wr_data_reg & NPTX_WR_MASK) |
                      (np_tx_word & ~NPTX_WR_MASK); // RULE12 RULE13
      end
      if (np_sent && NEXT_PAGE_EN) begin
        np_tx_word[NPTX_TOGGLE_BIT] <= ~np_tx_word[NPTX_TOGGLE_BIT]; // RULE14
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      partner_base_reg <= 16'h0000;
      np_rx_reg <= 16'h0000;
    end else if (page_in.load) begin
      if (page_in.base) begin
        partner_base_reg <= page_in.word & PARTNER_MASK; // RULE9
      end else begin
        np_rx_reg <= page_in.word; // RULE16
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      page_rx_reg <= 1'b0;
    end else if (page_in.load) begin
      page_rx_reg <= 1'b1; // RULE19 RULE10
    end else if (rd_exp_reg) begin
      page_rx_reg <= 1'b0; // RULE10
    end
  end

  //------------------------------------------------------------------
  // Read data selection
  //------------------------------------------------------------------
  always_comb begin
    rd_word = 16'h0000; // RULE17
    unique case (addr_reg)
      ADDR_ID_HIGH: rd_word = ORG_ID_HIGH; // RULE1
      ADDR_ID_LOW: rd_word = {ORG_ID_LOW, 10'h000}; // RULE1
      ADDR_LOCAL_ADV: rd_word = local_adv;
      ADDR_PARTNER_BASE: rd_word = partner_base_reg;
      ADDR_EXPANSION: begin
        rd_word[EXP_NP_ABLE_BIT] = 1'b1; // RULE11
        rd_word[EXP_PAGE_RX_BIT] = page_rx_reg;
      end
      ADDR_NP_TX: rd_word = NEXT_PAGE_EN ? np_tx_word : 16'h0000; // RULE15
      ADDR_NP_RX: rd_word = np_rx_reg;
      default: rd_word = 16'h0000; // RULE17
    endcase
  end

  //------------------------------------------------------------------
  // Checks
  //------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence read_turn_s;
    mdc_rise && state_reg == S_TA && cnt_reg == 4'h0 && rd_hit_reg;
  endsequence

  sequence exp_read_s;
    read_turn_s ##0 addr_reg == ADDR_EXPANSION;
  endsequence

  a_adv_reset_value: assert property (disable iff (1'b0) // RULE18
    rst |=> local_adv == ADV_RESET && np_tx_word == NPTX_RESET)
    else $error("Registers not at defaults after reset.");
  a_np_bit_fixed: assert property ( // RULE4
    local_adv[ADV_NP_BIT] == 1'b0 && local_adv[ADV_HALF_BIT] == 1'b0)
    else $error("Next-page or half-duplex bit set.");
  a_adv_reserved_zero: assert property ( // RULE7
    (local_adv & ~ADV_WR_MASK) == 16'h0000)
    else $error("Reserved advertisement bit set.");
  a_rf_self_clear: assert property ( // RULE2
    an_complete |=> local_adv[ADV_RF_HI:ADV_RF_LO] == RF_NO_ERROR)
    else $error("Remote fault did not clear after negotiation.");
  a_cfg_port_load: assert property ( // RULE8
    adv_cfg.valid && !wr_adv && !an_complete
    |=> local_adv == ($past(adv_cfg.word) & ADV_WR_MASK))
    else $error("Configuration port load lost.");
  a_page_rx_set: assert property ( // RULE19
    page_in.load |=> page_rx_reg)
    else $error("Page-received flag not set with page.");
  a_page_rx_clear: assert property ( // RULE10
    exp_read_s ##1 !page_in.load |=> !page_rx_reg)
    else $error("Page-received flag not cleared by read.");
  a_partner_store: assert property ( // RULE9
    page_in.load && page_in.base
    |=> partner_base_reg == ($past(page_in.word) & PARTNER_MASK))
    else $error("Partner base page not stored.");
  a_np_tx_hidden: assert property ( // RULE15
    addr_reg == ADDR_NP_TX && !NEXT_PAGE_EN |-> rd_word == 16'h0000)
    else $error("Next-page transmit word not zero.");
  a_toggle_flip: assert property ( // RULE14
    np_sent && NEXT_PAGE_EN |=> np_tx_word[NPTX_TOGGLE_BIT] !=
      $past(np_tx_word[NPTX_TOGGLE_BIT]))
    else $error("Toggle bit did not alternate.");
  a_read_drive: assert property ( // turnaround driven low on read
    read_turn_s |=> !mdio_oe_n && !mdio_out)
    else $error("Turnaround zero not driven on read.");
  a_id_low_word: assert property ( // RULE1
    addr_reg == ADDR_ID_LOW |-> rd_word[9:0] == 10'h000)
    else $error("Model or revision bits not zero.");

endmodule : autoneg_mgmt_registers

/* File: autoneg_pkg.sv */
// Constants and carrier types for the negotiation management registers.
package autoneg_pkg;

  // Register addresses on the serial management bus.
  localparam logic [4:0] ADDR_ID_HIGH = 5'h02;
  localparam logic [4:0] ADDR_ID_LOW = 5'h03;
  localparam logic [4:0] ADDR_LOCAL_ADV = 5'h04;
  localparam logic [4:0] ADDR_PARTNER_BASE = 5'h05;
  localparam logic [4:0] ADDR_EXPANSION = 5'h06;
  localparam logic [4:0] ADDR_NP_TX = 5'h07;
  localparam logic [4:0] ADDR_NP_RX = 5'h08;

  // Local advertisement layout.
  localparam logic [15:0] ADV_WR_MASK = 16'h31a0;
  localparam logic [15:0] ADV_RESET = 16'h01a0;
  localparam int ADV_NP_BIT = 15;
  localparam int ADV_HALF_BIT = 6;
  localparam int ADV_RF_HI = 13;
  localparam int ADV_RF_LO = 12;
  localparam int ADV_PAUSE_HI = 8;
  localparam int ADV_PAUSE_LO = 7;
  localparam logic [1:0] RF_NO_ERROR = 2'h0;
  localparam logic [1:0] PAUSE_BOTH = 2'h3;

  // Partner base page layout.
  localparam logic [15:0] PARTNER_MASK = 16'hf1e0;

  // Expansion word layout.
  localparam int EXP_NP_ABLE_BIT = 2;
  localparam int EXP_PAGE_RX_BIT = 1;

  // Next-page transmit layout.
  localparam logic [15:0] NPTX_WR_MASK = 16'hb7ff;
  localparam logic [15:0] NPTX_RESET = 16'h2001;
  localparam int NPTX_TOGGLE_BIT = 11;
  localparam int NP_MSG_PAGE_BIT = 13;

  // Management frame fields.
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [3:0] HDR_LAST = 4'hb;
  localparam logic [3:0] DATA_LAST = 4'hf;
  localparam logic [3:0] TA_LAST = 4'h1;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_START = 3'b001,
    S_HDR = 3'b010,
    S_TA = 3'b011,
    S_DATA = 3'b100
  } mgmt_state_t;

  // A page handed over by the negotiation engine.
  typedef struct packed {
    logic load;
    logic base;
    logic [15:0] word;
  } page_in_t;

  // Local advertisement loaded from the configuration port.
  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } adv_cfg_t;

endpackage : autoneg_pkg

/* File: mdio_station.sv */
// Behavioural management station on the far side of the serial pins.
`timescale 1ns/10ps

module mdio_station (
  // Management pins
  output logic mdc,
  output logic mdio_wire,
  input wire logic mdio_out,
  input wire logic mdio_oe_n
);
  import autoneg_pkg::*;

  logic drv = 1'h0;
  logic bit_v = 1'h1;

  initial mdc = 1'h0;

  // The pull-up holds the wire high whenever nobody drives it.
  assign mdio_wire = !mdio_oe_n ? mdio_out : (drv ? bit_v : 1'h1);

  //------------------------------------------------------------------
  // Frame task
  //------------------------------------------------------------------
  // The clock only runs inside frames; data changes while it is low.
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
      input logic [4:0] ra, input logic [15:0] wd,
      output logic [15:0] rd);
    logic [34:0] v;
    v = {4'hd, op, pa, ra, 2'h2, wd, 1'h1};
    rd = 16'h0000;
    for (int i = 34; i >= 0; i--) begin
      drv = (i >= 19) || (op == OP_WRITE && i >= 1);
      bit_v = v[i];
      #80 mdc = 1'h1;
      if (i >= 1 && i <= 16) begin
        rd[i-1] = mdio_wire;
      end
      #80 mdc = 1'h0;
    end
    drv = 1'h0;
    #400;
  endtask : frame
endmodule : mdio_station

/* File: testbench.sv */
// Self-checking bench for the negotiation management registers.
`timescale 1ns/10ps

module testbench;
  import autoneg_pkg::*;

  `define CHK(nm, ex, got) begin if ((got) !== (ex)) begin \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
    miscompares++; end num_checks++; end

  typedef struct packed {
    logic wr;
    logic [4:0] a;
    logic [15:0] wd;
    logic [15:0] ex;
  } row_t;

  localparam logic [4:0] PHY = 5'h03;
  localparam logic [4:0] PEER_PHY = 5'h04;
  localparam row_t ROWS[20] = '{
    '{1'h0, 5'h04, 16'h0, 16'h01a0}, '{1'h0, 5'h06, 16'h0, 16'h0004},
    '{1'h0, 5'h07, 16'h0, 16'h0000}, '{1'h0, 5'h05, 16'h0, 16'h0000},
    '{1'h0, 5'h08, 16'h0, 16'h0000}, '{1'h0, 5'h02, 16'h0, 16'h5a5a},
    '{1'h0, 5'h03, 16'h0, 16'hb000}, '{1'h1, 5'h04, 16'hffff, 16'h31a0},
    '{1'h1, 5'h04, 16'h0, 16'h0000}, '{1'h1, 5'h04, 16'h1080, 16'h1080},
    '{1'h1, 5'h04, 16'h2100, 16'h2100}, '{1'h1, 5'h02, 16'h0, 16'h5a5a},
    '{1'h1, 5'h03, 16'hffff, 16'hb000}, '{1'h1, 5'h05, 16'hffff, 16'h0},
    '{1'h1, 5'h06, 16'hffff, 16'h0004}, '{1'h1, 5'h07, 16'hffff, 16'h0},
    '{1'h1, 5'h08, 16'hffff, 16'h0}, '{1'h1, 5'h09, 16'hffff, 16'h0},
    '{1'h1, 5'h1f, 16'h1234, 16'h0}, '{1'h1, 5'h04, 16'h2100, 16'h2100}
  };

  logic clk = 1'h0;
  logic reset = 1'h1;
  logic soft_reset = 1'h0;
  logic locked = 1'h1;
  logic an_complete = 1'h0;
  logic np_sent = 1'h0;
  page_in_t page_in = '0;
  adv_cfg_t adv_cfg = '0;
  logic mdc, mdio_wire, mdio_out, mdio_oe_n;
  logic [15:0] local_adv, np_tx_word, rd;
  logic [15:0] peer_local_adv, peer_np_tx_word;
  int miscompares = 0;
  int num_checks = 0;

  always #10 clk = ~clk;

  autoneg_mgmt_registers i_autoneg_mgmt_registers (
    .clk(clk), .reset(reset), .soft_reset(soft_reset),
    .clock_manager_locked(locked), .mdc(mdc), .mdio_in(mdio_wire),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phy_addr(PHY),
    .page_in(page_in), .adv_cfg(adv_cfg), .an_complete(an_complete),
    .np_sent(np_sent), .local_adv(local_adv), .np_tx_word(np_tx_word)
  );

  // A second device with next pages enabled listens on the same wire.
  autoneg_mgmt_registers #(
    .NEXT_PAGE_EN(1'b1)
  ) i_autoneg_mgmt_registers_np (
    .clk(clk), .reset(reset), .soft_reset(soft_reset),
    .clock_manager_locked(locked), .mdc(mdc), .mdio_in(mdio_wire),
    .mdio_out(), .mdio_oe_n(), .phy_addr(PEER_PHY),
    .page_in(page_in), .adv_cfg(adv_cfg), .an_complete(an_complete),
    .np_sent(np_sent), .local_adv(peer_local_adv),
    .np_tx_word(peer_np_tx_word)
  );

  mdio_station i_mdio_station (
    .mdc(mdc), .mdio_wire(mdio_wire), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n)
  );

  //------------------------------------------------------------------
  // Tasks
  //------------------------------------------------------------------
  task automatic mwrite(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] x;
    i_mdio_station.frame(OP_WRITE, PHY, a, d, x);
  endtask : mwrite

  task automatic mread(input logic [4:0] a, output logic [15:0] d);
    i_mdio_station.frame(OP_READ, PHY, a, 16'h0, d);
  endtask : mread

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  initial begin
    #1000000;
    miscompares++;
    stop_test();
  end

  //------------------------------------------------------------------
  // Main sequence
  //------------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clk);
    `CHK("adv in reset", ADV_RESET, local_adv)
    `CHK("nptx in reset", NPTX_RESET, np_tx_word)
    reset = 1'h0;
    repeat (6) @(negedge clk);
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) mwrite(ROWS[i].a, ROWS[i].wd);
      mread(ROWS[i].a, rd);
      `CHK("table read", ROWS[i].ex, rd)
    end
    `CHK("bus released", 1'h1, mdio_oe_n)
    $display("table test done");
    @(negedge clk) adv_cfg = '{1'h1, 16'hffff};
    @(negedge clk) adv_cfg = '0;
    @(negedge clk) `CHK("cfg load", 16'h31a0, local_adv)
    an_complete = 1'h1;
    @(negedge clk) an_complete = 1'h0;
    @(negedge clk) `CHK("fault clear", 16'h01a0, local_adv)
    $display("engine test done");
    page_in = '{1'h1, 1'h1, 16'hffff};
    @(negedge clk) page_in = '0;
    @(negedge clk) mread(ADDR_PARTNER_BASE, rd);
    `CHK("base page", 16'hf1e0, rd)
    mread(ADDR_EXPANSION, rd);
    `CHK("flag set", 16'h0006, rd)
    mread(ADDR_EXPANSION, rd);
    `CHK("flag cleared", 16'h0004, rd)
    @(negedge clk) page_in = '{1'h1, 1'h0, 16'h5a3c};
    @(negedge clk) page_in = '0;
    @(negedge clk) mread(ADDR_NP_RX, rd);
    `CHK("next page", 16'h5a3c, rd)
    mread(ADDR_EXPANSION, rd);
    `CHK("np flag", 16'h0006, rd)
    $display("page test done");
    `CHK("nptx stored", 16'hb7ff, np_tx_word)
    @(negedge clk) np_sent = 1'h1;
    @(negedge clk) np_sent = 1'h0;
    @(negedge clk) `CHK("toggle frozen", 16'hb7ff, np_tx_word)
    `CHK("toggle flips", 16'h2801, peer_np_tx_word)
    i_mdio_station.frame(OP_WRITE, PEER_PHY, ADDR_LOCAL_ADV, 16'h0, rd);
    `CHK("other phy", 16'h01a0, local_adv)
    `CHK("peer phy write", 16'h0000, peer_local_adv)
    $display("next page test done");
    mwrite(ADDR_LOCAL_ADV, 16'h0);
    @(negedge clk) soft_reset = 1'h1;
    @(negedge clk) soft_reset = 1'h0;
    `CHK("soft reset", ADV_RESET, local_adv)
    `CHK("soft nptx", NPTX_RESET, np_tx_word)
    repeat (6) @(negedge clk);
    mwrite(ADDR_LOCAL_ADV, 16'h0);
    @(negedge clk) locked = 1'h0;
    repeat (4) @(negedge clk);
    `CHK("lock loss", ADV_RESET, local_adv)
    locked = 1'h1;
    repeat (6) @(negedge clk);
    mread(ADDR_LOCAL_ADV, rd);
    `CHK("after lock", ADV_RESET, rd)
    page_in = '{1'h1, 1'h1, 16'hffff};
    @(negedge clk) page_in = '0;
    @(negedge clk) reset = 1'h1;
    repeat (3) @(negedge clk);
    reset = 1'h0;
    repeat (6) @(negedge clk);
    mread(ADDR_PARTNER_BASE, rd);
    `CHK("core reset", 16'h0000, rd)
    $display("reset test done");
    stop_test();
  end
endmodule : testbench
